// ===== include/dbs_pkg.sv
// Purpose: Shared constants for the two-word DDR burst SRAM port and its controller.
// Assumes: One link beat is one rising edge of the link clock; kphase marks K or K-bar.
// Notes: The stop wait count STOP_CYC is derived from the controller clock period; lock counts are in beats.
package dbs_pkg;
  localparam int DATA_W_DEF = 18;
  localparam int ADDR_W_DEF = 8;
  localparam int LANE_W = 9;
  localparam int LOCK_CYCLES = 1024;
  localparam int LOCK_W = 11;
  localparam int RD_WORD0_EDGE = 3;
  localparam int DOFF_LOW_BEATS = 2;
  localparam int DIV_W = 8;
  localparam int DIV_MIN = 4;
  localparam int DIV_DEF = 4;
  localparam int CLK_NS = 8;
  localparam int STOP_NS = 30;
  localparam int STOP_CYC = (STOP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic DOFF_RST = 1'b0;
  localparam logic SEL_IDLE = 1'b1;
endpackage

// ===== include/dbs_link_if.sv
// Purpose: Pin bundle between the burst SRAM port and its controller.
// Assumes: The controller makes k_clk; the SRAM end runs on it.
// Notes: q is only meaningful while q_oe is high; the SRAM end alone drives it and holds it otherwise.
`timescale 1ns/1ps
interface dbs_link_if #(
  parameter int DATA_W = dbs_pkg::DATA_W_DEF,
  parameter int ADDR_W = dbs_pkg::ADDR_W_DEF
);
  localparam int LANES = DATA_W / dbs_pkg::LANE_W;
  logic k_clk;
  logic kphase;
  logic rd_sel_n;
  logic wr_sel_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] d;
  logic [LANES-1:0] byte_mask_n;
  logic doff_n;
  logic oclk_high;
  logic [DATA_W-1:0] q;
  logic q_oe;
  logic echo_clock;
  modport ctrl (
    output k_clk, kphase, rd_sel_n, wr_sel_n, addr, d, byte_mask_n, doff_n, oclk_high,
    input q, q_oe, echo_clock
  );
  modport dev (
    input k_clk, kphase, rd_sel_n, wr_sel_n, addr, d, byte_mask_n, doff_n, oclk_high,
    output q, q_oe, echo_clock
  );
endinterface

// ===== hw/dbs_sram_dev.sv
// Purpose: SRAM end of the two-word DDR burst port, one link beat per k_clk rising edge.
// Assumes: kphase high marks a K edge, low a K-bar edge; rst_n_i is synchronous to k_clk.
// Notes: A stopped k_clk simply freezes every register here, which keeps all outputs.
`timescale 1ns/1ps
// Contract
// - Read at K edge returns words in t+1, t+2.
// - Two-lane width: low mask stores that byte.
// - Four-lane width: each mask gates its byte.
// - Nine-bit width: one mask gates whole word.
// - Masks matter only on write burst beats.
// - Finish bursts before clock stop; hold state.
// - Controller resets lock on frequency change.
// - Reads only after 1024 lock cycles.
// - Idle: no operation, outputs released after bursts.
// - First word after K-bar, second next K.
// - Controller gives word one, then word two.
// - Output clock held high selects input timing.
module dbs_sram_dev #(
  parameter int DATA_W = dbs_pkg::DATA_W_DEF,
  parameter int ADDR_W = dbs_pkg::ADDR_W_DEF
) (
  input wire logic rst_n_i,
  output logic dll_locked_o,
  output logic single_clk_o,
  dbs_link_if.dev link
);
  localparam int LANES = DATA_W / dbs_pkg::LANE_W;
  localparam int PW = dbs_pkg::RD_WORD0_EDGE + 1;
  localparam int DEPTH = 2 ** (ADDR_W + 1);

  if (!(DATA_W == 9 || DATA_W == 18 || DATA_W == 36) || ADDR_W < 1) begin : g_bad_cfg
    $error("dbs_sram_dev: DATA_W must be 9, 18 or 36 and ADDR_W at least 1");
  end

  if (dbs_pkg::RD_WORD0_EDGE < 2) begin : g_bad_pipe
    $error("dbs_sram_dev: the read pipe needs at least two edges before word 0");
  end

  logic [DATA_W-1:0] mem [0:DEPTH-1];

  logic [dbs_pkg::LOCK_W-1:0] lock_cnt;
  logic [dbs_pkg::LOCK_W-1:0] next_lock_cnt;
  logic locked;
  logic next_locked;
  logic single;
  logic next_single;
  logic strap_done;
  logic next_strap_done;
  logic [ADDR_W-1:0] rd_addr;
  logic [ADDR_W-1:0] next_rd_addr;
  logic [ADDR_W-1:0] rd_addr_out;
  logic [ADDR_W-1:0] next_rd_addr_out;
  logic [PW-1:0] rpipe;
  logic [PW-1:0] next_rpipe;
  logic wr_pend;
  logic next_wr_pend;
  logic [DATA_W-1:0] wr_d0;
  logic [DATA_W-1:0] next_wr_d0;
  logic [LANES-1:0] wr_m0;
  logic [LANES-1:0] next_wr_m0;
  logic [DATA_W-1:0] q;
  logic [DATA_W-1:0] next_q;
  logic q_oe;
  logic next_q_oe;
  logic echo;
  logic next_echo;
  logic rd_go;
  logic wr_go;
  logic wr_commit;
  logic [ADDR_W:0] wa0;
  logic [ADDR_W:0] wa1;

  // Expands active-low lane masks into a per-bit write enable.
  function automatic logic [DATA_W-1:0] lane_bits(input logic [LANES-1:0] mask_n);
    logic [DATA_W-1:0] en;
    en = '0;
    for (int i = 0; i < LANES; i++) begin
      en[i*dbs_pkg::LANE_W +: dbs_pkg::LANE_W] = {dbs_pkg::LANE_W{~mask_n[i]}};
    end
    return en;
  endfunction

  // Lanes whose enable is low keep the word already stored.
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [DATA_W-1:0] en
  );
    return (old_w & ~en) | (new_w & en);
  endfunction

  // Read and write starts are decoded apart, so both may start on one K edge.
  assign rd_go = link.kphase & ~link.rd_sel_n;
  assign wr_go = link.kphase & ~link.wr_sel_n;
  // The write address rides the K-bar edge of the burst, beside the second word.
  assign wr_commit = ~link.kphase & wr_pend;
  // Word 0 of a burst sits at the even index, word 1 at the odd one.
  assign wa0 = {link.addr, 1'b0};
  assign wa1 = {link.addr, 1'b1};

  always_comb begin
    next_lock_cnt = lock_cnt;
    next_locked = locked;
    next_single = single;
    next_strap_done = strap_done;
    next_rd_addr = rd_addr;
    next_rd_addr_out = rd_addr_out;
    // Each read start walks down rpipe; its last two taps pick the word slots.
    next_rpipe = {rpipe[PW-2:0], rd_go};
    next_wr_pend = wr_pend;
    next_wr_d0 = wr_d0;
    next_wr_m0 = wr_m0;
    next_q = q;
    next_q_oe = 1'b0;
    next_echo = ~echo;
    // Lock restarts whenever the lock-disable input is seen low.
    if (!link.doff_n) begin
      next_lock_cnt = '0;
      next_locked = 1'b0;
    end else if (!locked) begin
      next_lock_cnt = lock_cnt + 1'b1;
      if (lock_cnt == dbs_pkg::LOCK_W'(dbs_pkg::LOCK_CYCLES - 1)) begin
        next_locked = 1'b1;
      end
    end
    // The output-clock strap is caught once, on the first edge after reset.
    if (!strap_done) begin
      next_single = link.oclk_high;
      next_strap_done = 1'b1;
    end
    if (rd_go) begin
      next_rd_addr = link.addr;
    end
    // A read may start on the next K edge, before this one has left, so its address moves on.
    if (rpipe[PW-3]) begin
      next_rd_addr_out = rd_addr;
    end
    // Masks are latched only with a write start and used only on its K-bar beat.
    if (wr_go) begin
      next_wr_pend = 1'b1;
      next_wr_d0 = link.d;
      next_wr_m0 = link.byte_mask_n;
    end else if (wr_commit) begin
      next_wr_pend = 1'b0;
    end
    // Word 0 goes out on the K-bar edge of cycle t+1, word 1 on the K edge of t+2.
    if (rpipe[PW-2]) begin
      next_q = mem[{rd_addr_out, 1'b0}];
      next_q_oe = 1'b1;
    end else if (rpipe[PW-1]) begin
      next_q = mem[{rd_addr_out, 1'b1}];
      next_q_oe = 1'b1;
    end
    // In single clock mode the echo follows the input pair rather than free-running.
    if (single) begin
      next_echo = link.kphase;
    end
  end

  // Reset clears the read pipe, so no word leaves for a read started before it.
  always_ff @(posedge link.k_clk) begin
    if (!rst_n_i) begin
      lock_cnt <= '0;
      locked <= 1'b0;
      single <= 1'b0;
      strap_done <= 1'b0;
      rd_addr <= '0;
      rd_addr_out <= '0;
      rpipe <= '0;
      wr_pend <= 1'b0;
      wr_d0 <= '0;
      wr_m0 <= '1;
      q <= '0;
      q_oe <= 1'b0;
      echo <= 1'b0;
    end else begin
      lock_cnt <= next_lock_cnt;
      locked <= next_locked;
      single <= next_single;
      strap_done <= next_strap_done;
      rd_addr <= next_rd_addr;
      rd_addr_out <= next_rd_addr_out;
      rpipe <= next_rpipe;
      wr_pend <= next_wr_pend;
      wr_d0 <= next_wr_d0;
      wr_m0 <= next_wr_m0;
      q <= next_q;
      q_oe <= next_q_oe;
      echo <= next_echo;
    end
  end

  // Both beats land together so a burst is never half written.
  // Lane count follows DATA_W: one lane gates the whole nine-bit word.
  always_ff @(posedge link.k_clk) begin
    if (rst_n_i && wr_commit) begin
      mem[wa0] <= merge(mem[wa0], wr_d0, lane_bits(wr_m0));
      mem[wa1] <= merge(mem[wa1], link.d, lane_bits(link.byte_mask_n));
    end
  end

  // A stopped k_clk freezes the registers above, so outputs hold their state.
  assign link.q = q;
  assign link.q_oe = q_oe;
  assign link.echo_clock = echo;
  assign dll_locked_o = locked;
  assign single_clk_o = single;
endmodule

// ===== hw/dbs_ctrl.sv
// Purpose: Controller end that makes k_clk and issues two-word read and write bursts.
// Assumes: Requests are held until their ack; div_i sets the half period in clk_i cycles.
// Notes: Read data passes three flops and is taken mid-beat, so the half period must be >= 4.
`timescale 1ns/1ps
module dbs_ctrl #(
  parameter int DATA_W = dbs_pkg::DATA_W_DEF,
  parameter int ADDR_W = dbs_pkg::ADDR_W_DEF,
  parameter int DIV_INIT = dbs_pkg::DIV_DEF,
  parameter bit SINGLE_CLK = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic stop_i,
  input wire logic [dbs_pkg::DIV_W-1:0] div_i,
  input wire logic rd_req_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic rd_ack_o,
  output logic rd_valid_o,
  output logic [2*DATA_W-1:0] rd_data_o,
  input wire logic wr_req_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [2*DATA_W-1:0] wr_data_i,
  input wire logic [2*(DATA_W/9)-1:0] wr_mask_n_i,
  output logic wr_ack_o,
  output logic locked_o,
  output logic stopped_o,
  dbs_link_if.ctrl link
);
  localparam int LN = DATA_W / dbs_pkg::LANE_W;
  localparam int PW = dbs_pkg::RD_WORD0_EDGE + 2;
  localparam int SW = 4;

  if (!(DATA_W == 9 || DATA_W == 18 || DATA_W == 36) || DIV_INIT < dbs_pkg::DIV_MIN
      || DIV_INIT > 255) begin : g_bad_cfg
    $error("dbs_ctrl: DATA_W must be 9, 18 or 36 and DIV_INIT within 4..255");
  end

  typedef enum logic [1:0] {CS_RELOCK, CS_LOCK, CS_RUN, CS_STOP} dbs_cst_e;

  function automatic logic [dbs_pkg::DIV_W-1:0] clamp_div(input logic [dbs_pkg::DIV_W-1:0] v);
    return (v < dbs_pkg::DIV_W'(dbs_pkg::DIV_MIN)) ? dbs_pkg::DIV_W'(dbs_pkg::DIV_MIN) : v;
  endfunction

  dbs_cst_e st, next_st;
  logic [dbs_pkg::DIV_W-1:0] cnt, next_cnt, div, next_div;
  logic [dbs_pkg::LOCK_W-1:0] lcnt, next_lcnt;
  logic [SW-1:0] scnt, next_scnt;
  logic kclk, next_kclk, kph, next_kph, rsel_n, next_rsel_n, wsel_n, next_wsel_n;
  logic doff_n, next_doff_n, ohigh;
  logic [ADDR_W-1:0] addr, next_addr, wa_h, next_wa_h;
  logic [DATA_W-1:0] d, next_d, wd_h, next_wd_h;
  logic [LN-1:0] bw, next_bw, wm_h, next_wm_h;
  logic [PW-1:0] rp, next_rp;
  logic rd_launch, next_rd_launch, wr_pend, next_wr_pend;
  logic rack, next_rack, wack, next_wack, rvalid, next_rvalid, locked, next_locked;
  logic [2*DATA_W-1:0] rdata, next_rdata;
  logic [DATA_W-1:0] q_s1, q_s2, q_s3;
  logic tick, rise, fall, div_chg;
  logic stopped, next_stopped;

  assign tick = (st != CS_STOP) && (cnt == div - 1'b1);
  assign rise = tick & ~kclk;
  assign fall = tick & kclk;
  assign div_chg = clamp_div(div_i) != div;

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_div = div;
    next_lcnt = lcnt;
    next_scnt = scnt;
    next_kclk = kclk;
    next_kph = kph;
    next_rsel_n = rsel_n;
    next_wsel_n = wsel_n;
    next_doff_n = doff_n;
    next_addr = addr;
    next_d = d;
    next_bw = bw;
    next_wa_h = wa_h;
    next_wd_h = wd_h;
    next_wm_h = wm_h;
    next_rp = rp;
    next_rd_launch = rd_launch;
    next_wr_pend = wr_pend;
    next_rdata = rdata;
    next_rack = rack;
    next_wack = wack;
    next_rvalid = rvalid;
    next_locked = locked;
    if (ce_i) begin
      next_rack = 1'b0;
      next_wack = 1'b0;
      next_rvalid = 1'b0;
      if (st != CS_STOP) begin
        next_cnt = tick ? '0 : cnt + 1'b1;
      end
      if (tick) begin
        next_kclk = ~kclk;
      end
      if (rise) begin
        next_rp = {rp[PW-2:0], rd_launch};
        next_rd_launch = 1'b0;
        if (st == CS_RELOCK) begin
          next_lcnt = lcnt + 1'b1;
          if (lcnt == dbs_pkg::LOCK_W'(dbs_pkg::DOFF_LOW_BEATS - 1)) begin
            next_st = CS_LOCK;
            next_lcnt = '0;
          end
        end else if (st == CS_LOCK) begin
          next_lcnt = lcnt + 1'b1;
          if (lcnt == dbs_pkg::LOCK_W'(dbs_pkg::LOCK_CYCLES - 1)) begin
            next_st = CS_RUN;
            next_locked = 1'b1;
          end
        end
      end
      if (fall) begin
        next_kph = ~kph;
        // The lock reset ends on a fall, so no k_clk rise sees it move.
        if (st == CS_LOCK) begin
          next_doff_n = 1'b1;
        end
        if (rp[PW-2]) begin
          next_rdata[DATA_W-1:0] = q_s3;
        end
        if (rp[PW-1]) begin
          next_rdata[2*DATA_W-1:DATA_W] = q_s3;
          next_rvalid = 1'b1;
        end
        next_rsel_n = dbs_pkg::SEL_IDLE;
        next_wsel_n = dbs_pkg::SEL_IDLE;
        next_bw = '1;
        if (!kph) begin
          // Stop only once every burst has drained and its outputs are released.
          if (st == CS_RUN && (stop_i || div_chg) && rp == '0 && !rd_launch) begin
            next_st = CS_STOP;
            next_scnt = '0;
            next_locked = 1'b0;
          end else begin
            if (rd_req_i && st == CS_RUN) begin
              next_rsel_n = 1'b0;
              next_addr = rd_addr_i;
              next_rd_launch = 1'b1;
              next_rack = 1'b1;
            end
            if (wr_req_i && st != CS_RELOCK) begin
              next_wsel_n = 1'b0;
              next_d = wr_data_i[DATA_W-1:0];
              next_bw = wr_mask_n_i[LN-1:0];
              next_wa_h = wr_addr_i;
              next_wd_h = wr_data_i[2*DATA_W-1:DATA_W];
              next_wm_h = wr_mask_n_i[2*LN-1:LN];
              next_wr_pend = 1'b1;
              next_wack = 1'b1;
            end
          end
        end else if (wr_pend) begin
          next_addr = wa_h;
          next_d = wd_h;
          next_bw = wm_h;
          next_wr_pend = 1'b0;
        end
      end
      if (st == CS_STOP) begin
        // The clock rests low for at least the DLL reset time, then the DLL is relocked.
        if (scnt != SW'(dbs_pkg::STOP_CYC)) begin
          next_scnt = scnt + 1'b1;
        end else if (!stop_i) begin
          next_div = clamp_div(div_i);
          next_st = CS_RELOCK;
          next_doff_n = dbs_pkg::DOFF_RST;
          next_lcnt = '0;
          next_cnt = '0;
        end
      end
    end
    next_stopped = (next_st == CS_STOP);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= CS_RELOCK;
      cnt <= '0;
      div <= dbs_pkg::DIV_W'(DIV_INIT);
      lcnt <= '0;
      scnt <= '0;
      kclk <= 1'b0;
      kph <= 1'b0;
      rsel_n <= dbs_pkg::SEL_IDLE;
      wsel_n <= dbs_pkg::SEL_IDLE;
      doff_n <= dbs_pkg::DOFF_RST;
      addr <= '0;
      d <= '0;
      bw <= '1;
      wa_h <= '0;
      wd_h <= '0;
      wm_h <= '1;
      rp <= '0;
      rd_launch <= 1'b0;
      wr_pend <= 1'b0;
      rdata <= '0;
      rack <= 1'b0;
      wack <= 1'b0;
      rvalid <= 1'b0;
      locked <= 1'b0;
      stopped <= 1'b0;
      ohigh <= SINGLE_CLK;
      q_s1 <= '0;
      q_s2 <= '0;
      q_s3 <= '0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      div <= next_div;
      lcnt <= next_lcnt;
      scnt <= next_scnt;
      kclk <= next_kclk;
      kph <= next_kph;
      rsel_n <= next_rsel_n;
      wsel_n <= next_wsel_n;
      doff_n <= next_doff_n;
      addr <= next_addr;
      d <= next_d;
      bw <= next_bw;
      wa_h <= next_wa_h;
      wd_h <= next_wd_h;
      wm_h <= next_wm_h;
      rp <= next_rp;
      rd_launch <= next_rd_launch;
      wr_pend <= next_wr_pend;
      rdata <= next_rdata;
      rack <= next_rack;
      wack <= next_wack;
      rvalid <= next_rvalid;
      locked <= next_locked;
      stopped <= next_stopped;
      ohigh <= SINGLE_CLK;
      // Read data comes from the k_clk domain; it is taken only mid-beat when settled.
      if (ce_i) begin
        q_s1 <= link.q;
        q_s2 <= q_s1;
        q_s3 <= q_s2;
      end
    end
  end

  assign link.k_clk = kclk;
  assign link.kphase = kph;
  assign link.rd_sel_n = rsel_n;
  assign link.wr_sel_n = wsel_n;
  assign link.addr = addr;
  assign link.d = d;
  assign link.byte_mask_n = bw;
  assign link.doff_n = doff_n;
  assign link.oclk_high = ohigh;
  assign rd_ack_o = rack;
  assign wr_ack_o = wack;
  assign rd_valid_o = rvalid;
  assign rd_data_o = rdata;
  assign locked_o = locked;
  assign stopped_o = stopped;
endmodule

// ===== verif/dbs_link_chk.sv
// Purpose: Assertions on the link between the burst SRAM port and its controller.
// Assumes: Sampled on k_clk rises; rst_n_i is the SRAM end reset.
// Notes: The lock count ignores reset, so a late SRAM reset cannot hide an early read.
`timescale 1ns/1ps
module dbs_link_chk #(
  parameter int DATA_W = dbs_pkg::DATA_W_DEF,
  parameter int ADDR_W = dbs_pkg::ADDR_W_DEF
) (
  input wire logic rst_n_i,
  input wire logic k_clk,
  input wire logic kphase,
  input wire logic rd_sel_n,
  input wire logic wr_sel_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] d,
  input wire logic [DATA_W/9-1:0] byte_mask_n,
  input wire logic doff_n,
  input wire logic oclk_high,
  input wire logic [DATA_W-1:0] q,
  input wire logic q_oe,
  input wire logic echo_clock
);
  logic [11:0] lock_cnt;
  logic [11:0] next_lock_cnt;
  logic [2:0] run_cnt;
  logic [2:0] next_run_cnt;
  logic rd_go;
  assign rd_go = kphase && !rd_sel_n;
  always_comb begin
    next_lock_cnt = lock_cnt;
    next_run_cnt = run_cnt;
    if (!doff_n) begin
      next_lock_cnt = 12'h000;
    end else if (lock_cnt < 12'h7ff) begin
      next_lock_cnt = lock_cnt + 12'h001;
    end
    if (!rst_n_i) begin
      next_run_cnt = 3'h0;
    end else if (run_cnt < 3'h7) begin
      next_run_cnt = run_cnt + 3'h1;
    end
  end
  always_ff @(posedge k_clk) begin
    lock_cnt <= next_lock_cnt;
    run_cnt <= next_run_cnt;
  end
  default clocking cb @(posedge k_clk);
  endclocking
  default disable iff (!rst_n_i);
  property p_rd_beats;
    rd_go |-> ##4 q_oe ##1 q_oe;
  endproperty
  a_rd_beats: assert property (p_rd_beats) else $error("read words late");
  property p_oe_span;
    run_cnt == 3'h7 |-> q_oe == ($past(rd_go, 4) || $past(rd_go, 5));
  endproperty
  a_oe_span: assert property (p_oe_span) else $error("output enable span wrong");
  property p_q_hold;
    !q_oe |-> $stable(q);
  endproperty
  a_q_hold: assert property (p_q_hold) else $error("idle read data moved");
  property p_echo;
    $past(rst_n_i) && !oclk_high |-> echo_clock != $past(echo_clock);
  endproperty
  a_echo: assert property (p_echo) else $error("echo clock stuck");
  property p_lock;
    rd_go |-> lock_cnt >= 12'h400;
  endproperty
  a_lock: assert property (p_lock) else $error("read before lock period");
  property p_kphase;
    doff_n && $past(doff_n) |-> kphase != $past(kphase);
  endproperty
  a_kphase: assert property (p_kphase) else $error("beat phase not alternating");
  property p_doff_len;
    $fell(doff_n) |-> ##[1:3] doff_n;
  endproperty
  a_doff_len: assert property (p_doff_len) else $error("lock reset too long");
  property p_idle_sel;
    !doff_n |-> rd_sel_n && wr_sel_n;
  endproperty
  a_idle_sel: assert property (p_idle_sel) else $error("access during lock reset");
  property p_strap;
    $stable(oclk_high);
  endproperty
  a_strap: assert property (p_strap) else $error("clock mode strap moved");
endmodule

// ===== verif/test_ddr_burst2_sram_port.sv
// Purpose: Self-checking bench for the burst SRAM port joined to its controller.
// Assumes: k_clk half period is four clk_i cycles, five after the stop test moves it.
// Notes: Expected memory is kept here and merged lane by lane from the masks.
`timescale 1ns/1ps
module test_ddr_burst2_sram_port;
  logic clk_i = 1'b0;
  logic rst_n = 1'b0;
  logic dev_rst_n = 1'b0;
  logic stop = 1'b0;
  logic ce = 1'b1;
  logic [7:0] div = 8'h04;
  logic rd_req = 1'b0;
  logic wr_req = 1'b0;
  logic [7:0] rd_addr = 8'h00;
  logic [7:0] wr_addr = 8'h00;
  logic [35:0] wr_data = 36'h000000000;
  logic [3:0] wr_mask_n = 4'hf;
  logic [35:0] rd_data;
  logic rd_ack, rd_valid, wr_ack, locked, stopped, dll_locked, single_clk;
  logic [35:0] exp_mem [0:255];
  int miscompares = 0;
  int n_compared = 0;
  dbs_link_if link ();
  always #4 clk_i = ~clk_i;
  dbs_ctrl i_dbs_ctrl (
    .clk_i(clk_i), .rst_n_i(rst_n), .ce_i(ce), .stop_i(stop), .div_i(div),
    .rd_req_i(rd_req), .rd_addr_i(rd_addr), .rd_ack_o(rd_ack), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .wr_req_i(wr_req), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
    .wr_mask_n_i(wr_mask_n), .wr_ack_o(wr_ack), .locked_o(locked), .stopped_o(stopped),
    .link(link));
  dbs_sram_dev i_dbs_sram_dev (
    .rst_n_i(dev_rst_n), .dll_locked_o(dll_locked), .single_clk_o(single_clk), .link(link));
  dbs_link_chk i_dbs_link_chk (
    .rst_n_i(dev_rst_n), .k_clk(link.k_clk), .kphase(link.kphase),
    .rd_sel_n(link.rd_sel_n), .wr_sel_n(link.wr_sel_n), .addr(link.addr), .d(link.d),
    .byte_mask_n(link.byte_mask_n), .doff_n(link.doff_n), .oclk_high(link.oclk_high),
    .q(link.q), .q_oe(link.q_oe), .echo_clock(link.echo_clock));

  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    n_compared++;
    if (exp !== got) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [35:0] dat, input logic [3:0] m);
    int i;
    tick();
    wr_addr = a;
    wr_data = dat;
    wr_mask_n = m;
    wr_req = 1'b1;
    for (i = 0; i < 400 && wr_ack !== 1'b1; i++) begin
      tick();
    end
    wr_req = 1'b0;
    check("write ack", 36'h1, 36'(wr_ack));
    for (i = 0; i < 4; i++) begin
      if (!m[i]) begin
        exp_mem[a][9*i +: 9] = dat[9*i +: 9];
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input string what);
    int i;
    tick();
    rd_addr = a;
    rd_req = 1'b1;
    for (i = 0; i < 400 && rd_ack !== 1'b1; i++) begin
      tick();
    end
    rd_req = 1'b0;
    for (i = 0; i < 400 && rd_valid !== 1'b1; i++) begin
      tick();
    end
    check("read valid", 36'h1, 36'(rd_valid));
    check(what, exp_mem[a], rd_data);
  endtask

  task automatic t_lock();
    int i;
    logic [1:0] k0;
    for (i = 0; i < 10000 && locked !== 1'b1; i++) begin
      tick();
    end
    check("lock cycles", 36'h1, 36'(i >= 8000));
    check("device lock", 36'h1, 36'(dll_locked));
    check("clock mode", 36'h0, {34'h0, link.oclk_high, single_clk});
    // While the enable is low the link clock and its phase must not move.
    k0 = {link.k_clk, link.kphase};
    ce = 1'b0;
    for (i = 0; i < 20; i++) begin
      tick();
      check("frozen controller", {34'h0, k0}, {34'h0, link.k_clk, link.kphase});
    end
    ce = 1'b1;
    $display("t_lock done");
  endtask

  task automatic t_masks();
    int m;
    wr(8'h20, 36'h0a5a5a5a5, 4'h0);
    wr(8'h30, 36'h3c3c3c3c3, 4'h0);
    wr(8'h10, 36'h5a5a5a5a5, 4'h0);
    for (m = 0; m < 16; m++) begin
      wr(8'h10, {4{m[3:0], 5'h0a}}, m[3:0]);
      rd(8'h10, "masked burst");
    end
    $display("t_masks done");
  endtask

  task automatic t_concurrent();
    int i;
    tick();
    rd_addr = 8'h20;
    wr_addr = 8'h21;
    wr_data = 36'h123456789;
    wr_mask_n = 4'h0;
    rd_req = 1'b1;
    wr_req = 1'b1;
    for (i = 0; i < 400 && (rd_req || wr_req); i++) begin
      tick();
      if (rd_ack === 1'b1) begin
        rd_req = 1'b0;
      end
      if (wr_ack === 1'b1) begin
        wr_req = 1'b0;
      end
    end
    for (i = 0; i < 400 && rd_valid !== 1'b1; i++) begin
      tick();
    end
    check("concurrent read", exp_mem[8'h20], rd_data);
    exp_mem[8'h21] = 36'h123456789;
    rd(8'h21, "concurrent write");
    // Holding the request past its ack starts a second read on the very next K edge.
    tick();
    rd_addr = 8'h10;
    rd_req = 1'b1;
    for (i = 0; i < 400 && rd_ack !== 1'b1; i++) begin
      tick();
    end
    rd_addr = 8'h21;
    tick();
    for (i = 0; i < 400 && rd_ack !== 1'b1; i++) begin
      tick();
    end
    rd_req = 1'b0;
    for (i = 0; i < 400 && rd_valid !== 1'b1; i++) begin
      tick();
    end
    check("first of two reads", exp_mem[8'h10], rd_data);
    tick();
    for (i = 0; i < 400 && rd_valid !== 1'b1; i++) begin
      tick();
    end
    check("second of two reads", exp_mem[8'h21], rd_data);
    $display("t_concurrent done");
  endtask

  task automatic t_stop();
    int i;
    logic [17:0] q0;
    fork
      rd(8'h30, "read across stop");
      begin
        @(posedge rd_ack);
        #1;
        stop = 1'b1;
        // A new half period is only taken up through the stop and relock.
        div = 8'h05;
      end
    join
    for (i = 0; i < 400 && stopped !== 1'b1; i++) begin
      tick();
    end
    check("stopped", 36'h1, 36'(stopped));
    q0 = link.q;
    for (i = 0; i < 40; i++) begin
      tick();
      check("frozen link", {17'h0, q0, 1'b0}, {17'h0, link.q, link.k_clk});
    end
    stop = 1'b0;
    repeat (100) tick();
    check("lock dropped", 36'h0, {34'h0, locked, dll_locked});
    for (i = 100; i < 12000 && locked !== 1'b1; i++) begin
      tick();
    end
    check("relock cycles", 36'h1, 36'(i >= 8192));
    check("device relock", 36'h1, 36'(dll_locked));
    rd(8'h10, "kept after stop");
    $display("t_stop done");
  endtask

  task automatic end_of_test();
    $display("Compared %0d values, %0d mismatches", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #(8 * 60000);
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (6) tick();
    rst_n = 1'b1;
    repeat (2) @(posedge link.k_clk);
    tick();
    dev_rst_n = 1'b1;
    t_lock();
    t_masks();
    t_concurrent();
    t_stop();
    end_of_test();
  end
endmodule
